// ### hw/rgrc_top.sv
// Purpose: receive state, gain step, strength readout, filter setting, current limit, thermometer
// Assumes: 50 MHz clk; level and strength inputs come from the analog front end, async to clk
// Notes: strength and level are in half-dB magnitude units of input power below 0 dBm
// Functional notes
// - trim code maps to PA current ceiling
// - receive enabled until preamble or strength
// - gain step from five ascending thresholds
// - strength reported in half-dB absolute units
// - signed correction -16..+15 dB applied
// - averaging 2 to 256 samples, 3 bits
// - recalibrate strength on calibration launch
// - channel filter is 16-tap FIR
// - bandwidth from mantissa and exponent plus two
// - thermometer runs except sleep, standby; disable bit
// - measurement stored in thermometer result
`timescale 1ns/1ps
`default_nettype none
module rgrc_top #(
  parameter int TEMP_CYCLES = rgrc_pkg::RGRC_TEMP_CYC,
  parameter int LW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire rgrc_pkg::rgrc_mode_e op_mode,
  input wire logic [4:0] pa_current_limit_trim,
  output logic [7:0] pa_current_ceiling_ma,
  input wire logic [LW-1:0] rx_input_level,
  input wire logic [rgrc_pkg::RGRC_AGC_THRESH*LW-1:0] agc_level_threshold,
  output logic [2:0] lna_gain_step_code,
  input wire logic preamble_valid,
  input wire logic strength_detect,
  output logic rx_active,
  input wire logic strength_sample_valid,
  input wire logic [7:0] strength_sample,
  input wire rgrc_pkg::rgrc_ss_cfg_s strength_cfg,
  input wire logic calibration_start,
  output logic [7:0] signal_strength_reading,
  output logic strength_calibrated,
  input wire rgrc_pkg::rgrc_bw_s channel_filter_bandwidth,
  output rgrc_pkg::rgrc_bw_s filter_bw_active,
  output logic [5:0] filter_bw_divider_log2,
  output logic [4:0] filter_bw_mantissa_value,
  input wire logic fir_in_valid,
  input wire logic signed [11:0] fir_in_data,
  output logic fir_out_valid,
  output logic signed [23:0] fir_out_data,
  input wire logic thermometer_disable,
  input wire logic [7:0] temp_sensor_raw,
  output logic thermometer_running,
  output logic [7:0] thermometer_result
);
  import rgrc_pkg::*;
  initial begin
    if (TEMP_CYCLES < 1 || LW < 2 || LW > 16) $error("bad rgrc_top parameters");
  end
  ////////////////////////////////////////////////////////////
  // reset release and input synchronisers
  logic rst_s1_reg, rst_n;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n <= rst_s1_reg;
    end
  end
  logic [1:0] pre_s_reg, det_s_reg, sv_s_reg;
  logic [LW-1:0] lvl_s1_reg, lvl_reg;
  logic [7:0] smp_s1_reg, smp_reg, tmp_s1_reg, tmp_reg;
  // pins from the analog side pass two flops before use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_s_reg <= '0;
      det_s_reg <= '0;
      sv_s_reg <= '0;
      lvl_s1_reg <= '0;
      lvl_reg <= '0;
      smp_s1_reg <= '0;
      smp_reg <= '0;
      tmp_s1_reg <= '0;
      tmp_reg <= '0;
    end else begin
      pre_s_reg <= {pre_s_reg[0], preamble_valid};
      det_s_reg <= {det_s_reg[0], strength_detect};
      sv_s_reg <= {sv_s_reg[0], strength_sample_valid};
      lvl_s1_reg <= rx_input_level;
      lvl_reg <= lvl_s1_reg;
      smp_s1_reg <= strength_sample;
      smp_reg <= smp_s1_reg;
      tmp_s1_reg <= temp_sensor_raw;
      tmp_reg <= tmp_s1_reg;
    end
  end
  // sample strobe edge, read from the second stage only
  logic sv_d_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) sv_d_reg <= 1'b0;
    else sv_d_reg <= sv_s_reg[1];
  end
  wire sv_pulse = sv_s_reg[1] & ~sv_d_reg;
  ////////////////////////////////////////////////////////////
  // current ceiling lookup
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pa_current_ceiling_ma <= RGRC_OCP_BASE_LO;
    end else if (pa_current_limit_trim < RGRC_OCP_SPLIT) begin
      pa_current_ceiling_ma <= 8'(RGRC_OCP_BASE_LO + RGRC_OCP_STEP_LO * {3'h0, pa_current_limit_trim});
    end else if (pa_current_limit_trim <= RGRC_OCP_LAST) begin
      pa_current_ceiling_ma <= 8'(9'(RGRC_OCP_STEP_HI * {3'h0, pa_current_limit_trim}) - RGRC_OCP_BASE_HI);
    end else begin
      pa_current_ceiling_ma <= RGRC_OCP_CEIL;
    end
  end
  ////////////////////////////////////////////////////////////
  // receive state: enabled until a start condition, then active
  typedef enum logic [1:0] {RGRC_RX_OFF, RGRC_RX_ENABLED, RGRC_RX_ACTIVE} rgrc_rx_e;
  rgrc_rx_e rx_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= RGRC_RX_OFF;
    end else if (op_mode != RGRC_MODE_RX) begin
      rx_reg <= RGRC_RX_OFF;
    end else begin
      unique case (rx_reg)
        RGRC_RX_OFF: rx_reg <= RGRC_RX_ENABLED;
        RGRC_RX_ENABLED: if (pre_s_reg[1] || det_s_reg[1]) rx_reg <= RGRC_RX_ACTIVE;
        RGRC_RX_ACTIVE: rx_reg <= RGRC_RX_ACTIVE;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) rx_active <= 1'b0;
    else rx_active <= (rx_reg == RGRC_RX_ACTIVE) && (op_mode == RGRC_MODE_RX);
  end
  ////////////////////////////////////////////////////////////
  // gain step: count thresholds the level exceeds
  logic [2:0] above;
  always_comb begin
    above = 3'h0;
    for (int t = 0; t < RGRC_AGC_THRESH; t++) begin
      if (lvl_reg > agc_level_threshold[t*LW +: LW]) above = above + 3'h1;
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lna_gain_step_code <= RGRC_G1;
    end else begin
      unique case (above)
        3'h0: lna_gain_step_code <= RGRC_G1;
        3'h1: lna_gain_step_code <= RGRC_G2;
        3'h2: lna_gain_step_code <= RGRC_G3;
        3'h3: lna_gain_step_code <= RGRC_G4;
        3'h4: lna_gain_step_code <= RGRC_G5;
        default: lna_gain_step_code <= RGRC_G6;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////
  // strength averaging: block average over 2^(n+1) samples
  logic [15:0] acc_reg;
  logic [8:0] cnt_reg;
  logic cal_reg;
  wire [8:0] n_target = 9'h002 << strength_cfg.avg_count;
  wire [15:0] acc_sum = acc_reg + {8'h00, smp_reg};
  // shift sum kept 4 bits wide, code 7 must shift by 8, not wrap to 0
  wire [15:0] avg = acc_sum >> (4'(strength_cfg.avg_count) + 4'h1);
  // correction is in dB, the reading in half dB, so doubled
  wire signed [10:0] corr_half = 11'(signed'(strength_cfg.correction)) <<< 1;
  wire signed [10:0] adj = signed'({3'h0, avg[7:0]}) + corr_half;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      signal_strength_reading <= RGRC_RSSI_RST;
    end else if (calibration_start) begin
      acc_reg <= '0;
      cnt_reg <= '0;
    end else if (sv_pulse && cal_reg) begin
      if (9'(cnt_reg + 9'h001) >= n_target) begin
        acc_reg <= '0;
        cnt_reg <= '0;
        if (adj < 0) signal_strength_reading <= 8'h00;
        else if (adj > 11'sd255) signal_strength_reading <= 8'hff;
        else signal_strength_reading <= adj[7:0];
      end else begin
        acc_reg <= acc_sum;
        cnt_reg <= 9'(cnt_reg + 9'h001);
      end
    end
  end
  // calibration flag: readings are held until a calibration has run
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cal_reg <= 1'b0;
    else if (calibration_start) cal_reg <= 1'b1;
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) strength_calibrated <= 1'b0;
    else strength_calibrated <= cal_reg;
  end
  ////////////////////////////////////////////////////////////
  // filter bandwidth setting, reserved codes ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_bw_active <= '{mant: RGRC_MANT_RST, expo: RGRC_EXP_RST};
    end else if (channel_filter_bandwidth.mant != 2'h3 && channel_filter_bandwidth.expo >= RGRC_EXP_MIN) begin
      filter_bw_active <= channel_filter_bandwidth;
    end
  end
  // divisor = mantissa * 2^(exp+2): mantissa value and power of two
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filter_bw_divider_log2 <= 6'h00;
      filter_bw_mantissa_value <= 5'h00;
    end else begin
      filter_bw_divider_log2 <= {3'h0, filter_bw_active.expo} + 6'h02;
      unique case (filter_bw_active.mant)
        RGRC_MANT_16: filter_bw_mantissa_value <= 5'h10;
        RGRC_MANT_20: filter_bw_mantissa_value <= 5'h14;
        RGRC_MANT_24: filter_bw_mantissa_value <= 5'h18;
        default: filter_bw_mantissa_value <= filter_bw_mantissa_value;
      endcase
    end
  end
  // channel filter
  rgrc_fir16 #(.TAPS(RGRC_FIR_TAPS), .DW(12)) u_fir (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(fir_in_valid),
    .in_data(fir_in_data),
    .out_valid(fir_out_valid),
    .out_data(fir_out_data)
  );
  ////////////////////////////////////////////////////////////
  // thermometer: runs outside sleep and standby unless disabled
  wire temp_on = !thermometer_disable && op_mode != RGRC_MODE_SLEEP && op_mode != RGRC_MODE_STANDBY;
  logic [31:0] tcnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thermometer_running <= 1'b0;
      tcnt_reg <= '0;
      thermometer_result <= RGRC_TEMP_RST;
    end else begin
      thermometer_running <= temp_on;
      if (!temp_on) begin
        tcnt_reg <= '0;
      end else if (tcnt_reg >= 32'(TEMP_CYCLES - 1)) begin
        tcnt_reg <= '0;
        thermometer_result <= tmp_reg;
      end else begin
        tcnt_reg <= tcnt_reg + 32'h1;
      end
    end
  end
endmodule
`default_nettype wire

// ### hw/rgrc_pkg.sv
// Purpose: shared constants and carriers for the receive control and readout block
// Assumes: 50 MHz core clock
// Notes: all fields are plain ports, no register bus
package rgrc_pkg;
  // operating modes of the surrounding sequencer
  typedef enum logic [2:0] {
    RGRC_MODE_SLEEP = 3'h0,
    RGRC_MODE_STANDBY = 3'h1,
    RGRC_MODE_FSTX = 3'h2,
    RGRC_MODE_TX = 3'h3,
    RGRC_MODE_RECEIVE_SYNTH_MODE = 3'h4,
    RGRC_MODE_RX = 3'h5
  } rgrc_mode_e;
  // current limit table
  localparam logic [7:0] RGRC_OCP_BASE_LO = 8'h2d;
  localparam logic [7:0] RGRC_OCP_STEP_LO = 8'h05;
  localparam logic [8:0] RGRC_OCP_BASE_HI = 9'h01e;
  localparam logic [7:0] RGRC_OCP_STEP_HI = 8'h0a;
  localparam logic [4:0] RGRC_OCP_SPLIT = 5'h10;
  localparam logic [4:0] RGRC_OCP_LAST = 5'h1b;
  localparam logic [7:0] RGRC_OCP_CEIL = 8'hf0;
  // gain step codes
  localparam logic [2:0] RGRC_G1 = 3'h1;
  localparam logic [2:0] RGRC_G2 = 3'h2;
  localparam logic [2:0] RGRC_G3 = 3'h3;
  localparam logic [2:0] RGRC_G4 = 3'h4;
  localparam logic [2:0] RGRC_G5 = 3'h6;
  localparam logic [2:0] RGRC_G6 = 3'h7;
  localparam int RGRC_AGC_THRESH = 5;
  // filter bandwidth fields
  localparam logic [1:0] RGRC_MANT_16 = 2'h0;
  localparam logic [1:0] RGRC_MANT_20 = 2'h1;
  localparam logic [1:0] RGRC_MANT_24 = 2'h2;
  localparam logic [2:0] RGRC_EXP_MIN = 3'h1;
  localparam logic [2:0] RGRC_EXP_RST = 3'h5;
  localparam logic [1:0] RGRC_MANT_RST = 2'h1;
  localparam int RGRC_FIR_TAPS = 16;
  // strength reading
  localparam logic [7:0] RGRC_RSSI_RST = 8'hff;
  localparam int RGRC_SS_OFFSET = -137;
  // timing
  localparam int RGRC_CLK_MHZ = 50;
  localparam int RGRC_TEMP_US = 140;
  localparam int RGRC_TEMP_CYC = RGRC_TEMP_US * RGRC_CLK_MHZ;
  localparam logic [7:0] RGRC_TEMP_RST = 8'h00;
  // bandwidth setting carrier
  typedef struct packed {
    logic [1:0] mant;
    logic [2:0] expo;
  } rgrc_bw_s;
  // strength configuration carrier
  typedef struct packed {
    logic signed [4:0] correction;
    logic [2:0] avg_count;
  } rgrc_ss_cfg_s;
endpackage

// ### hw/rgrc_fir16.sv
// Purpose: 16-tap channel filter on a sample stream
// Assumes: samples arrive with a one-cycle valid strobe
// Notes: coefficients are a fixed parameter, full-precision accumulation
`timescale 1ns/1ps
`default_nettype none
module rgrc_fir16 #(
  parameter int TAPS = rgrc_pkg::RGRC_FIR_TAPS,
  parameter int DW = 12,
  parameter logic [TAPS*8-1:0] COEF = {16{8'h08}}
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  input wire logic signed [DW-1:0] in_data,
  output logic out_valid,
  output logic signed [DW+11:0] out_data
);
  import rgrc_pkg::*;
  initial begin
    if (TAPS != 16) $error("filter must have 16 taps");
  end
  logic signed [DW-1:0] dly_reg [TAPS];
  logic signed [DW+11:0] prod [TAPS];
  logic signed [DW+11:0] sum_next;
  ////////////////////////////////////////////////////////////
  // delay line, one entry per tap
  genvar i;
  generate
    for (i = 0; i < TAPS; i++) begin : g_tap
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dly_reg[i] <= '0;
        end else if (in_valid) begin
          dly_reg[i] <= (i == 0) ? in_data : dly_reg[(i == 0) ? 0 : i-1];
        end
      end
      assign prod[i] = (DW+12)'(dly_reg[i] * $signed({1'b0, COEF[i*8 +: 8]}));
    end
  endgenerate
  // adder tree as a loop, combinational
  always_comb begin
    sum_next = '0;
    for (int k = 0; k < TAPS; k++) begin
      sum_next = sum_next + prod[k];
    end
  end
  // output register one cycle after each sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else begin
      out_valid <= in_valid;
      if (in_valid) out_data <= sum_next;
    end
  end
endmodule
`default_nettype wire

// ### bench/rgrc_props.sv
// Purpose: timing checks on the receive control block ports
// Assumes: bound to rgrc_top, one clock domain
// Notes: checks other than p_rx_off wait for the reset copy and input syncs to settle
`timescale 1ns/1ps
`default_nettype none
module rgrc_props #(
  parameter int LW = 8
) (
  input wire logic clk,
  input wire logic nrst,
  input wire rgrc_pkg::rgrc_mode_e op_mode,
  input wire logic [4:0] pa_current_limit_trim,
  input wire logic [7:0] pa_current_ceiling_ma,
  input wire logic [LW-1:0] rx_input_level,
  input wire logic [rgrc_pkg::RGRC_AGC_THRESH*LW-1:0] agc_level_threshold,
  input wire logic [2:0] lna_gain_step_code,
  input wire logic preamble_valid,
  input wire logic strength_detect,
  input wire logic rx_active,
  input wire logic [7:0] signal_strength_reading,
  input wire logic strength_calibrated,
  input wire rgrc_pkg::rgrc_bw_s channel_filter_bandwidth,
  input wire rgrc_pkg::rgrc_bw_s filter_bw_active,
  input wire logic [5:0] filter_bw_divider_log2,
  input wire logic [4:0] filter_bw_mantissa_value,
  input wire logic fir_in_valid,
  input wire logic fir_out_valid,
  input wire logic thermometer_disable,
  input wire logic thermometer_running
);
  import rgrc_pkg::*;
  logic [3:0] up_cnt;
  logic rdy;
  logic t_on;
  // settle counter, longer than reset copy plus syncs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst)
      up_cnt <= 4'h0;
    else if (up_cnt != 4'hf)
      up_cnt <= up_cnt + 4'h1;
  end
  assign rdy = up_cnt == 4'hf;
  assign t_on = !thermometer_disable && op_mode != RGRC_MODE_SLEEP && op_mode != RGRC_MODE_STANDBY;
  // 8-bit wrap keeps the upper segment exact
  function automatic logic [7:0] ceil_of(input logic [4:0] t);
    if (t < 5'h10)
      return 8'h2d + 8'h05 * {3'h0, t};
    if (t < 5'h1c)
      return 8'h0a * {3'h0, t} - 8'h1e;
    return 8'hf0;
  endfunction
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////
  property p_ceil; rdy |=> pa_current_ceiling_ma == ceil_of($past(pa_current_limit_trim)); endproperty
  property p_gain_lo; (rdy && rx_input_level <= agc_level_threshold[LW-1:0]) [*5] |-> lna_gain_step_code == 3'h1;
  endproperty
  property p_gain_hi; (rdy && rx_input_level > agc_level_threshold[5*LW-1:4*LW]) [*5] |-> lna_gain_step_code == 3'h7;
  endproperty
  property p_rx_on; (rdy && op_mode == RGRC_MODE_RX && (preamble_valid || strength_detect)) [*7] |-> rx_active;
  endproperty
  property p_rx_off; (op_mode != RGRC_MODE_RX) [*3] |-> !rx_active; endproperty
  property p_bw_keep; rdy && (channel_filter_bandwidth.mant == 2'h3 || channel_filter_bandwidth.expo == 3'h0)
    |=> $stable(filter_bw_active); endproperty
  property p_bw_div; rdy |=> filter_bw_divider_log2 == {3'h0, $past(filter_bw_active.expo)} + 6'h2 &&
    filter_bw_mantissa_value == 5'h10 + {1'b0, $past(filter_bw_active.mant), 2'h0}; endproperty
  property p_fir; rdy |=> fir_out_valid == $past(fir_in_valid); endproperty
  property p_therm; rdy && $stable(t_on) |-> thermometer_running == t_on; endproperty
  property p_precal; rdy && !strength_calibrated |-> signal_strength_reading == 8'hff; endproperty
  a_ceil: assert property (p_ceil) else $error("ceiling wrong");
  a_gain_lo: assert property (p_gain_lo) else $error("low gain step wrong");
  a_gain_hi: assert property (p_gain_hi) else $error("top gain step wrong");
  a_rx_on: assert property (p_rx_on) else $error("receiver not active");
  a_rx_off: assert property (p_rx_off) else $error("active outside receive");
  a_bw_keep: assert property (p_bw_keep) else $error("reserved bandwidth taken");
  a_bw_div: assert property (p_bw_div) else $error("bandwidth divider wrong");
  a_fir: assert property (p_fir) else $error("filter strobe wrong");
  a_therm: assert property (p_therm) else $error("thermometer state wrong");
  a_precal: assert property (p_precal) else $error("reading before calibration");
  c_rx: cover property ($rose(rx_active));
  c_keep: cover property (rdy && channel_filter_bandwidth.mant == 2'h3);
  c_cal: cover property (strength_calibrated && signal_strength_reading != 8'hff);
endmodule
bind rgrc_top rgrc_props #(.LW(LW)) u_props (.*);
`default_nettype wire

// ### bench/rgrc_host_model.sv
// Purpose: host model driving mode and thermometer control
// Assumes: bench changes requests just after the rising edge
// Notes: acts 2 ns after the edge, so it never races the bench
`timescale 1ns/1ps
`default_nettype none
module rgrc_host_model #(
  parameter int XOSC_CYC = 4,
  parameter int WAIT_CYC = 40
) (
  input wire logic clk,
  input wire rgrc_pkg::rgrc_mode_e mode_req,
  input wire logic temp_go,
  output rgrc_pkg::rgrc_mode_e op_mode,
  output logic thermometer_disable,
  output logic temp_done
);
  import rgrc_pkg::*;
  initial begin
    op_mode = RGRC_MODE_SLEEP;
    thermometer_disable = 1'b0;
    temp_done = 1'b0;
  end
  // follow the requested mode, or run one temperature reading
  always begin
    @(posedge clk);
    #2;
    if (temp_go && !temp_done) begin
      op_mode = RGRC_MODE_STANDBY;
      repeat (XOSC_CYC) @(posedge clk);
      #2;
      op_mode = RGRC_MODE_RECEIVE_SYNTH_MODE;
      thermometer_disable = 1'b0;
      repeat (WAIT_CYC) @(posedge clk);
      #2;
      thermometer_disable = 1'b1;
      op_mode = RGRC_MODE_STANDBY;
      temp_done = 1'b1;
    end else begin
      if (!temp_go)
        temp_done = 1'b0;
      if (!temp_done)
        op_mode = mode_req;
    end
  end
endmodule
`default_nettype wire

// ### bench/rgrc_top_bench.sv
// Purpose: self-checking bench for the receive control block
// Assumes: thermometer window shortened to 20 cycles
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module rgrc_top_bench;
  import rgrc_pkg::*;
  logic clk = 1'b0;
  logic nrst, preamble_valid, strength_detect, strength_sample_valid, calibration_start, fir_in_valid, temp_go;
  logic rx_active, strength_calibrated, fir_out_valid, thermometer_running, thermometer_disable, temp_done;
  logic [4:0] pa_current_limit_trim, filter_bw_mantissa_value, bw_exp;
  logic [7:0] rx_input_level, strength_sample, temp_sensor_raw, pa_current_ceiling_ma;
  logic [7:0] signal_strength_reading, thermometer_result;
  logic [39:0] agc_level_threshold;
  logic [2:0] lna_gain_step_code;
  logic [5:0] filter_bw_divider_log2;
  logic signed [11:0] fir_in_data;
  logic signed [23:0] fir_out_data, fir_first, fir_last;
  rgrc_ss_cfg_s strength_cfg;
  rgrc_bw_s channel_filter_bandwidth, filter_bw_active;
  rgrc_mode_e op_mode, mode_req;
  int fail_count = 0;
  int cmp_count = 0;
  int fir_n = 0;
  // host side bit-rate budget against a 32 MHz reference
  localparam int HOST_XOSC_HZ = 32000000;
  localparam int HOST_BPS = 4800;
  // gain table: level, expected step code
  localparam logic [10:0] AGC[12] = '{{8'h00, 3'h1}, {8'h14, 3'h1}, {8'h15, 3'h2}, {8'h28, 3'h2},
    {8'h29, 3'h3}, {8'h3c, 3'h3}, {8'h3d, 3'h4}, {8'h50, 3'h4}, {8'h51, 3'h6}, {8'h64, 3'h6},
    {8'h65, 3'h7}, {8'hff, 3'h7}};
  // strength table: correction, average code, sample, expected reading
  localparam logic [23:0] SS[9] = '{{5'h00, 3'h0, 8'h0a, 8'h0a}, {5'h10, 3'h1, 8'h64, 8'h44},
    {5'h0f, 3'h2, 8'hfa, 8'hff}, {5'h10, 3'h0, 8'h0a, 8'h00}, {5'h01, 3'h3, 8'h20, 8'h22},
    {5'h01, 3'h4, 8'h20, 8'h22}, {5'h01, 3'h5, 8'h20, 8'h22}, {5'h01, 3'h6, 8'h20, 8'h22},
    {5'h00, 3'h7, 8'h50, 8'h50}};
  rgrc_top #(.TEMP_CYCLES(20)) u_dut (.*);
  rgrc_host_model #(.WAIT_CYC(40)) u_host (.*);
  always #10 clk = ~clk;
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic stop_test;
    if (fail_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // strobes are held 3 cycles so the synchroniser sees each one
  task automatic samp(input logic [7:0] v, input int n);
    repeat (n) begin
      strength_sample = v;
      strength_sample_valid = 1'b1;
      tick(3);
      strength_sample_valid = 1'b0;
      tick(3);
    end
  endtask
  function automatic logic [23:0] ceil_of(input int t);
    return (t < 16) ? 45 + 5 * t : (t < 28) ? 10 * t - 30 : 240;
  endfunction
  // count filter output strobes, keep first and last word
  always @(posedge clk) begin
    if (fir_out_valid === 1'b1) begin
      if (fir_n == 0)
        fir_first = fir_out_data;
      fir_n++;
      fir_last = fir_out_data;
    end
  end
  initial begin
    #400000;
    fail_count++;
    stop_test;
  end
  ////////////////////////////////////////
  initial begin
    {nrst, preamble_valid, strength_detect, strength_sample_valid, calibration_start, fir_in_valid, temp_go} = '0;
    pa_current_limit_trim = '0;
    rx_input_level = '0;
    strength_sample = '0;
    temp_sensor_raw = 8'h11;
    agc_level_threshold = {8'h64, 8'h50, 8'h3c, 8'h28, 8'h14};
    fir_in_data = '0;
    strength_cfg = '0;
    channel_filter_bandwidth = '0;
    mode_req = RGRC_MODE_SLEEP;
    bw_exp = {2'h1, 3'h5};
    tick(12);
    nrst = 1'b1;
    tick(3);
    for (int t = 0; t < 32; t++) begin
      pa_current_limit_trim = 5'(t);
      tick(2);
      chk(pa_current_ceiling_ma, ceil_of(t));
    end
    foreach (AGC[i]) begin
      rx_input_level = AGC[i][10:3];
      tick(5);
      chk(lna_gain_step_code, AGC[i][2:0]);
    end
    for (int m = 0; m < 4; m++) begin
      for (int e = 0; e < 8; e++) begin
        channel_filter_bandwidth = {2'(m), 3'(e)};
        tick(3);
        if (m != 3 && e != 0)
          bw_exp = {2'(m), 3'(e)};
        chk(filter_bw_active, bw_exp);
        chk(filter_bw_divider_log2, bw_exp[2:0] + 6'h2);
        chk(filter_bw_mantissa_value, 5'h10 + {bw_exp[4:3], 2'h0});
      end
    end
    // last legal setting is 24 x 2^9: host rate must stay under twice that bandwidth
    chk(24'(2 * HOST_XOSC_HZ / (filter_bw_mantissa_value << filter_bw_divider_log2) > HOST_BPS), 24'(1));
    samp(8'h10, 2);
    chk(signal_strength_reading, 8'hff);
    foreach (SS[i]) begin
      strength_cfg = SS[i][23:16];
      calibration_start = 1'b1;
      tick(1);
      calibration_start = 1'b0;
      tick(2);
      chk(strength_calibrated, 1'b1);
      samp(SS[i][15:8], 2 << SS[i][18:16]);
      tick(2);
      chk(signal_strength_reading, SS[i][7:0]);
    end
    // spread-mode reading as the host sees it: raw 0x50 gives -57 dBm
    chk(24'(RGRC_SS_OFFSET + int'(signal_strength_reading)), 24'(-57));
    mode_req = RGRC_MODE_RX;
    tick(10);
    chk(rx_active, 1'b0);
    chk(thermometer_running, 1'b1);
    preamble_valid = 1'b1;
    tick(8);
    chk(rx_active, 1'b1);
    preamble_valid = 1'b0;
    mode_req = RGRC_MODE_STANDBY;
    tick(6);
    chk(rx_active, 1'b0);
    mode_req = RGRC_MODE_RX;
    strength_detect = 1'b1;
    tick(10);
    chk(rx_active, 1'b1);
    strength_detect = 1'b0;
    fir_in_data = 12'sd5;
    fir_in_valid = 1'b1;
    tick(16);
    fir_in_valid = 1'b0;
    tick(4);
    chk(fir_n, 16);
    // output lags one sample: first word sees an empty line, last sees 15 taps
    chk(fir_first, 24'sd0);
    chk(fir_last, 24'sd600);
    mode_req = RGRC_MODE_SLEEP;
    temp_sensor_raw = 8'h5a;
    temp_go = 1'b1;
    for (int i = 0; i < 300 && temp_done !== 1'b1; i++)
      tick(1);
    temp_go = 1'b0;
    chk(thermometer_result, 8'h5a);
    temp_sensor_raw = 8'h33;
    tick(40);
    chk(thermometer_running, 1'b0);
    chk(thermometer_result, 8'h5a);
    // disable bit alone must stop it in a running mode
    mode_req = RGRC_MODE_RX;
    tick(6);
    chk(thermometer_running, 1'b0);
    stop_test;
  end
endmodule
`default_nettype wire
